// >>> src/fifo_bus_map.svh
`ifndef FIFO_BUS_MAP_SVH
`define FIFO_BUS_MAP_SVH
// ----------------------------------------
// Register offsets and fields
// ----------------------------------------
`define CTL_OFFSET      4'h0
`define CAP_ADDR_OFFSET 4'h4
`define CAP_ATTR_OFFSET 4'h8
`define STATUS_OFFSET   4'hc
`define CTL_RESET       1'b1
`define ATTR_VALID_BIT  31
`define STAT_IRQ_BIT    9
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
// ----------------------------------------
// Local bus decode and timing
// ----------------------------------------
`define FIFO_REGION     20'h00010
`define FIFO_NONE       2'h3
`define TIMEOUT_COUNT   10'h3e8
`endif

// >>> src/fifo_bus_pkg.sv
package fifo_bus_pkg;
  typedef enum logic [7:0] {
    RD_IDLE  = 8'h01,
    RD_TURN  = 8'h02,
    RD_PULSE = 8'h04,
    RD_HOLD1 = 8'h08,
    RD_HOLD2 = 8'h10,
    RD_HOLD3 = 8'h20,
    RD_ACK   = 8'h40,
    RD_BEAT  = 8'h80
  } rd_phase_type;

  typedef struct packed {
    rd_phase_type phase;
    logic [1:0]   idx;
  } rd_state_type;

  typedef struct packed {
    logic        active, captured, cap_wr, cap_last;
    logic [9:0]  count;
    logic [29:0] cap_addr;
    logic [3:0]  cap_be;
  } mon_state_type;

  typedef struct packed {
    logic        awready, wready, bvalid, arready, rvalid;
    logic        aw_got, w_got, aw_ok, wbit, wstb;
    logic [3:0]  aw_off;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        ctl, ads_d1, ack, irq_n;
    logic [2:0]  enable_n, rclk;
  } state_type;
endpackage

// >>> src/lbus_if.sv
`timescale 1ns/1ps
interface lbus_if;
  logic        addr_strobe_n;
  logic        last_beat_n;
  logic        write_not_read;
  logic [3:0]  byte_lane_sel_n;
  logic [31:2] cpu_word_address;
  logic        bus_ready;
  modport fifo_side (input addr_strobe_n, last_beat_n, write_not_read, cpu_word_address);
  modport mon_side  (input addr_strobe_n, last_beat_n, write_not_read, byte_lane_sel_n,
                     cpu_word_address, bus_ready);
endinterface

// >>> src/fifo_read_ctl.sv
`timescale 1ns/1ps
`include "fifo_bus_map.svh"
module fifo_read_ctl
  import fifo_bus_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  lbus_if.fifo_side       bus,
  input  wire logic       slow_xcvr_direction,
  output logic [2:0]      oe_req,
  output logic [2:0]      rclk_req,
  output logic            ack_req
);
  rd_state_type s;
  rd_state_type n;
  logic         hit;
  logic         oe_on;
  logic         rclk_on;

  // Requests are next values; the top registers them onto the pins
  always_comb begin
    n       = s;
    oe_on   = 1'b0;
    rclk_on = 1'b0;
    ack_req = 1'b0;
    // Whole 1 KB window maps to one queue, so bursts stay on it
    hit = bus.cpu_word_address[31:12] == `FIFO_REGION &&
          bus.cpu_word_address[11:10] != `FIFO_NONE;
    case (s.phase)
      RD_IDLE: begin
        if (!bus.addr_strobe_n && !bus.write_not_read && hit) begin
          n.idx = bus.cpu_word_address[11:10];
          if (!slow_xcvr_direction) begin
            oe_on   = 1'b1;
            n.phase = RD_PULSE;
          end else begin
            n.phase = RD_TURN;
          end
        end
      end
      RD_TURN: begin
        if (!slow_xcvr_direction) begin
          oe_on   = 1'b1;
          n.phase = RD_PULSE;
        end
      end
      RD_PULSE: begin
        oe_on   = 1'b1;
        rclk_on = 1'b1;
        n.phase = RD_HOLD1;
      end
      RD_HOLD1: begin
        oe_on   = 1'b1;
        n.phase = RD_HOLD2;
      end
      RD_HOLD2: begin
        oe_on   = 1'b1;
        n.phase = RD_HOLD3;
      end
      RD_HOLD3: begin
        oe_on   = 1'b1;
        ack_req = 1'b1;
        n.phase = RD_ACK;
      end
      RD_ACK: begin
        if (!bus.last_beat_n) begin
          n.phase = RD_IDLE;
        end else begin
          oe_on   = 1'b1;
          rclk_on = 1'b1;
          n.phase = RD_BEAT;
        end
      end
      RD_BEAT: begin
        oe_on   = 1'b1;
        ack_req = 1'b1;
        n.phase = RD_ACK;
      end
      default: n.phase = RD_IDLE;
    endcase
    oe_req   = oe_on ? 3'(3'h1 << n.idx) : 3'h0;
    rclk_req = rclk_on ? 3'(3'h1 << s.idx) : 3'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s.phase <= RD_IDLE;
      s.idx   <= 2'h0;
    end else begin
      s <= n;
    end
  end
endmodule

// >>> src/bus_timeout_mon.sv
`timescale 1ns/1ps
`include "fifo_bus_map.svh"
module bus_timeout_mon
  import fifo_bus_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  lbus_if.mon_side         bus,
  input  wire logic        hold,
  output logic             ack_req,
  output logic             irq_req,
  output logic [29:0]      cap_addr,
  output logic [5:0]       cap_attr
);
  mon_state_type s;
  mon_state_type n;
  logic          live;
  logic          timeout;

  always_comb begin
    n       = s;
    live    = s.active || !bus.addr_strobe_n;
    timeout = live && !bus.bus_ready && s.count == `TIMEOUT_COUNT;
    if (hold) begin
      n = '0;
    end else if (!live) begin
      n.count = 10'h0;
    end else begin
      n.active = 1'b1;
      if (bus.bus_ready) begin
        n.count = 10'h0;
        if (!bus.last_beat_n) begin
          n.active = 1'b0;
        end
      end else if (timeout) begin
        // Each beat restarts its own wait
        n.count = 10'h0;
        if (!s.captured) begin
          n.captured = 1'b1;
          n.cap_addr = bus.cpu_word_address;
          n.cap_be   = bus.byte_lane_sel_n;
          n.cap_wr   = bus.write_not_read;
          n.cap_last = bus.last_beat_n;
        end
      end else begin
        n.count = s.count + 10'h1;
      end
    end
    ack_req  = timeout && !hold;
    irq_req  = s.captured;
    cap_addr = s.cap_addr;
    cap_attr = {s.cap_last, s.cap_wr, s.cap_be};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_count_step;
    @(posedge aclk) disable iff (!aresetn)
    s.active && !hold && !bus.bus_ready && s.count < `TIMEOUT_COUNT |=> s.count == $past(s.count) + 10'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("timeout counter did not step");

  property p_idle_clear;
    @(posedge aclk) disable iff (!aresetn)
    !s.active && bus.addr_strobe_n |=> s.count == 10'h0;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("counter not cleared when idle");

  property p_capture_kept;
    @(posedge aclk) disable iff (!aresetn)
    s.captured && !hold |=> s.captured && $stable(s.cap_addr) && $stable(s.cap_be);
  endproperty
  a_capture_kept: assert property (p_capture_kept) else $error("capture overwritten");
endmodule

// >>> src/fifo_bus_top.sv
// Function
// - Per queue: one enable line, one read clock
// - Enable, read clock next cycle, four waits
// - Enable only after transceiver turned to read
// - Bursts 4,1,1,1; whole window one queue
// - All read clocks pulse two after strobe
// - Queue flags readable by the processor
// - Queue accesses acknowledged by this block
// - Counter counts unacknowledged clocks, clears on ready
// - Counter cleared idle, stops at last ready
// - At 1000 the monitor acknowledges itself
// - Burst beats time out one by one
// - Timeout raises interrupt, captures access
// - First capture kept until monitor reset
// - Interrupt drives external interrupt input
// - Control 1 holds monitor, 0 enables
// - Control reads 1 after reset
`timescale 1ns/1ps
`include "fifo_bus_map.svh"
module fifo_bus_top
  import fifo_bus_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        addr_strobe_n,
  input  wire logic        last_beat_n,
  input  wire logic        write_not_read,
  input  wire logic [3:0]  byte_lane_sel_n,
  input  wire logic [31:2] cpu_word_address,
  input  wire logic        ready_n_i,
  output logic             ready_n_o,
  output logic             ready_oe,
  input  wire logic        slow_xcvr_direction,
  input  wire logic [2:0]  fifo_empty_n,
  input  wire logic [2:0]  fifo_half_n,
  input  wire logic [2:0]  fifo_full_n,
  output logic [2:0]       port_fifo_enable_n,
  output logic [2:0]       port_fifo_read_clock,
  output logic             ext_irq_six
);
  state_type   s;
  state_type   n;
  logic [2:0]  oe_req;
  logic [2:0]  rclk_req;
  logic        fifo_ack;
  logic        mon_ack;
  logic        irq_req;
  logic [29:0] cap_addr;
  logic [5:0]  cap_attr;
  lbus_if      bus ();

  // ----------------------------------------
  // Local bus view
  // ----------------------------------------
  assign bus.addr_strobe_n    = addr_strobe_n;
  assign bus.last_beat_n      = last_beat_n;
  assign bus.write_not_read   = write_not_read;
  assign bus.byte_lane_sel_n  = byte_lane_sel_n;
  assign bus.cpu_word_address = cpu_word_address;
  // Own drive counted too, in case the wire is not resolved outside
  assign bus.bus_ready        = !ready_n_i || s.ack;

  fifo_read_ctl u_fifo (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .bus                 (bus.fifo_side),
    .slow_xcvr_direction (slow_xcvr_direction),
    .oe_req              (oe_req),
    .rclk_req            (rclk_req),
    .ack_req             (fifo_ack)
  );

  bus_timeout_mon u_mon (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .bus      (bus.mon_side),
    .hold     (s.ctl),
    .ack_req  (mon_ack),
    .irq_req  (irq_req),
    .cap_addr (cap_addr),
    .cap_attr (cap_attr)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = s;
    // Pins
    n.enable_n = ~oe_req;
    // Flag-refresh pulse on every access; a popping pulse only where enabled
    n.ads_d1   = !addr_strobe_n;
    n.rclk     = {3{s.ads_d1}} | rclk_req;
    n.ack      = fifo_ack || mon_ack;
    n.irq_n    = !irq_req;
    // Write channel, address and data in either order
    if (s_axi_awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.aw_off = s_axi_awaddr[3:0];
      n.aw_ok  = s_axi_awaddr[31:4] == 28'h0;
    end
    if (s_axi_wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.wbit  = s_axi_wdata[0];
      n.wstb  = s_axi_wstrb[0];
    end
    if (s.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_got && n.w_got && !s.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = `RESP_SLVERR;
      if (n.aw_ok && n.aw_off == `CTL_OFFSET) begin
        n.bresp = `RESP_OKAY;
        if (n.wstb) begin
          n.ctl = n.wbit;
        end
      end else if (n.aw_ok && (n.aw_off == `CAP_ADDR_OFFSET || n.aw_off == `CAP_ATTR_OFFSET ||
                               n.aw_off == `STATUS_OFFSET)) begin
        // Read-only registers swallow writes
        n.bresp = `RESP_OKAY;
      end
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;
    // Read channel, one read under way at a time
    if (s.rvalid && s_axi_rready) begin
      n.rvalid  = 1'b0;
      n.arready = 1'b1;
    end
    if (s_axi_arvalid && s.arready) begin
      n.arready = 1'b0;
      n.rvalid  = 1'b1;
      n.rresp   = `RESP_OKAY;
      n.rdata   = 32'h0;
      if (s_axi_araddr[31:4] != 28'h0) begin
        n.rresp = `RESP_SLVERR;
      end else begin
        case (s_axi_araddr[3:0])
          `CTL_OFFSET:      n.rdata = {31'h0, s.ctl};
          `CAP_ADDR_OFFSET: n.rdata = {cap_addr, 2'h0};
          `CAP_ATTR_OFFSET: begin
            n.rdata = {26'h0, cap_attr};
            n.rdata[`ATTR_VALID_BIT] = irq_req;
          end
          `STATUS_OFFSET: begin
            n.rdata = {23'h0, fifo_full_n, fifo_half_n, fifo_empty_n};
            n.rdata[`STAT_IRQ_BIT] = irq_req;
          end
          default:          n.rresp = `RESP_SLVERR;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s          <= '0;
      s.awready  <= 1'b1;
      s.wready   <= 1'b1;
      s.arready  <= 1'b1;
      s.ctl      <= `CTL_RESET;
      s.irq_n    <= 1'b1;
      s.enable_n <= 3'h7;
    end else begin
      s <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready        = s.awready;
  assign s_axi_wready         = s.wready;
  assign s_axi_bvalid         = s.bvalid;
  assign s_axi_bresp          = s.bresp;
  assign s_axi_arready        = s.arready;
  assign s_axi_rvalid         = s.rvalid;
  assign s_axi_rresp          = s.rresp;
  assign s_axi_rdata          = s.rdata;
  assign ready_oe             = s.ack;
  assign ready_n_o            = !s.ack;
  assign port_fifo_enable_n   = s.enable_n;
  assign port_fifo_read_clock = s.rclk;
  assign ext_irq_six          = s.irq_n;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_status_pulse;
    !addr_strobe_n |-> ##2 (port_fifo_read_clock == 3'h7);
  endproperty
  a_status_pulse: assert property (p_status_pulse) else $error("no read clock two after strobe");

  property p_dir_first;
    (port_fifo_enable_n != 3'h7) && ($past(port_fifo_enable_n) == 3'h7) |-> !$past(slow_xcvr_direction);
  endproperty
  a_dir_first: assert property (p_dir_first) else $error("enable before turnaround");

  property p_single_read;
    $fell(port_fifo_enable_n[0]) |-> port_fifo_read_clock[0] == 1'b0 ##1 port_fifo_read_clock[0]
      ##1 !port_fifo_read_clock[0] && !ready_oe ##1 !ready_oe ##1 ready_oe;
  endproperty
  a_single_read: assert property (p_single_read) else $error("single read timing wrong");

  property p_burst_beat;
    ready_oe && (port_fifo_enable_n != 3'h7) && last_beat_n |=> !ready_oe ##1 ready_oe;
  endproperty
  a_burst_beat: assert property (p_burst_beat) else $error("burst beat not 1 wait");

  property p_timeout_ack;
    mon_ack |=> ready_oe && !ready_n_o ##1 !ext_irq_six;
  endproperty
  a_timeout_ack: assert property (p_timeout_ack) else $error("timeout ack or irq missing");

  property p_hold_clears;
    s.ctl [*3] |-> ext_irq_six && !mon_ack;
  endproperty
  a_hold_clears: assert property (p_hold_clears) else $error("held monitor still active");

  property p_irq_sticky;
    !ext_irq_six && !s.ctl |=> !ext_irq_six;
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("interrupt dropped while enabled");

  property p_ctl_after_reset;
    !$past(aresetn) |-> s.ctl;
  endproperty
  a_ctl_after_reset: assert property (p_ctl_after_reset) else $error("control not 1 after reset");

  c_single_read: cover property ($fell(port_fifo_enable_n[0]) ##4 ready_oe ##1 port_fifo_enable_n[0]);
  c_burst: cover property (ready_oe && last_beat_n && (port_fifo_enable_n != 3'h7) ##2 ready_oe);
  c_timeout: cover property (mon_ack ##2 !ext_irq_six);
  c_axi_write: cover property (s_axi_bvalid && s_axi_bready && !s.ctl);
endmodule

// >>> bench/fifo_far_end.sv
`timescale 1ns/1ps
module fifo_far_end #(
  parameter int FILL0     = 600,
  parameter int FILL1     = 1,
  parameter int FILL2     = 0,
  parameter int SLOW_WAIT = 900
) (
  input  wire logic        aclk,
  input  wire logic [2:0]  port_fifo_enable_n,
  input  wire logic [2:0]  port_fifo_read_clock,
  input  wire logic        ready_n_o,
  input  wire logic        ready_oe,
  input  wire logic        addr_strobe_n,
  input  wire logic        last_beat_n,
  input  wire logic [31:2] cpu_word_address,
  output wire logic [2:0]  fifo_empty_n,
  output wire logic [2:0]  fifo_half_n,
  output wire logic [2:0]  fifo_full_n,
  output wire logic        ready_n_i
);
  logic        busy = 1'b0;
  logic [10:0] cnt  = 11'h001;
  // ------------------------------
  // Queues
  // ------------------------------
  for (genvar i = 0; i < 3; i++) begin : q
    localparam int FILL = (i == 0) ? FILL0 : (i == 1) ? FILL1 : FILL2;
    int   level = FILL;
    logic e     = (FILL != 0);
    logic h     = (FILL < 512);
    logic f     = (FILL != 1024);
    // Flags move only here, never between read clocks
    always @(posedge port_fifo_read_clock[i]) begin
      if (port_fifo_enable_n[i] === 1'b0 && level > 0) begin
        level = level - 1;
      end
      e <= (level != 0);
      h <= (level < 512);
      f <= (level != 1024);
    end
    assign fifo_empty_n[i] = e;
    assign fifo_half_n[i]  = h;
    assign fifo_full_n[i]  = f;
  end
  // ------------------------------
  // Slow target at word space 8xxxxxxx
  // ------------------------------
  always @(posedge aclk) begin
    if (addr_strobe_n === 1'b0) begin
      busy <= (cpu_word_address[31:28] == 4'h8);
      cnt  <= 11'h001;
    end else if (busy) begin
      busy <= !(ready_n_i === 1'b0 && last_beat_n === 1'b0);
      cnt  <= (ready_n_i === 1'b0) ? 11'h001 : cnt + 11'h001;
    end
  end
  // Pulled-up line: any target may pull it low
  assign ready_n_i = (ready_oe ? ready_n_o : 1'b1) & !(busy && cnt == 11'(SLOW_WAIT));
endmodule

// >>> bench/fifo_read_and_bus_timeout_test.sv
`timescale 1ns/1ps
`include "fifo_bus_map.svh"
module fifo_read_and_bus_timeout_test
  import fifo_bus_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, byte_lane_sel_n = 4'h5;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        addr_strobe_n = 1'b1, last_beat_n = 1'b1, write_not_read = 1'b0;
  logic        slow_xcvr_direction = 1'b0, ready_n_o, ready_oe, ready_n_i, ext_irq_six;
  logic [31:2] cpu_word_address = 30'h0;
  logic [2:0]  fifo_empty_n, fifo_half_n, fifo_full_n, port_fifo_enable_n, port_fifo_read_clock;
  logic [2:0]  en1, rc2;
  int          fails = 0, check_count = 0, t0;
  int          rt[4];

  fifo_bus_top i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .addr_strobe_n, .last_beat_n, .write_not_read, .byte_lane_sel_n, .cpu_word_address,
    .ready_n_i, .ready_n_o, .ready_oe, .slow_xcvr_direction, .fifo_empty_n, .fifo_half_n,
    .fifo_full_n, .port_fifo_enable_n, .port_fifo_read_clock, .ext_irq_six
  );
  fifo_far_end i_far (
    .aclk, .port_fifo_enable_n, .port_fifo_read_clock, .ready_n_o, .ready_oe, .addr_strobe_n,
    .last_beat_n, .cpu_word_address, .fifo_empty_n, .fifo_half_n, .fifo_full_n, .ready_n_i
  );

  initial begin
    forever #4 aclk = ~aclk;
  end
  // ------------------------------
  // Checking and closing
  // ------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ------------------------------
  // Register bus master
  // ------------------------------
  task automatic axi(input logic wr, input logic [31:0] a, d, output logic [31:0] q, output logic [1:0] r);
    int   k;
    logic done;
    k = 0;
    done = 1'b0;
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
    end else begin
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
    end
    while (!done && k < 50) begin
      @(posedge aclk);
      k++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      done = wr ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1;
      q = s_axi_rdata;
      r = wr ? s_axi_bresp : s_axi_rresp;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (!done) begin
      fails++;
      test_done();
    end
  endtask
  task automatic rd_chk(input logic [31:0] a, exp, input logic [1:0] er, input string what);
    logic [31:0] q;
    logic [1:0]  r;
    axi(1'b0, a, 32'h0, q, r);
    check(q, exp, what);
    check({30'h0, r}, {30'h0, er}, "rresp");
  endtask
  task automatic wr_chk(input logic [31:0] a, d, input logic [1:0] er);
    logic [31:0] q;
    logic [1:0]  r;
    axi(1'b1, a, d, q, r);
    check({30'h0, r}, {30'h0, er}, "bresp");
  endtask
  task automatic wr_reg(input logic [31:0] d);
    wr_chk(32'(`CTL_OFFSET), d, `RESP_OKAY);
  endtask
  // ------------------------------
  // Local bus processor
  // ------------------------------
  task automatic lb(input logic [31:2] a, input logic wr, input int beats, input int hold_dir);
    int n, b;
    n = 0;
    b = 0;
    @(posedge aclk);
    addr_strobe_n       <= 1'b0;
    cpu_word_address    <= a;
    write_not_read      <= wr;
    last_beat_n         <= (beats != 1);
    slow_xcvr_direction <= (hold_dir != 0);
    @(posedge aclk);
    addr_strobe_n <= 1'b1;
    while (b < beats && n < 1100 * beats) begin
      #1;
      n++;
      if (n == 1) en1 = port_fifo_enable_n;
      if (n == 2) rc2 = port_fifo_read_clock;
      if (ready_n_i === 1'b0) begin
        rt[b] = n;
        b++;
      end
      @(posedge aclk);
      if (n == hold_dir) slow_xcvr_direction <= 1'b0;
      if (b > 0 && rt[b - 1] == n) cpu_word_address <= cpu_word_address + 30'h1;
      if (b == beats - 1) last_beat_n <= 1'b0;
    end
    t0 = rt[0];
    if (b < beats) begin
      fails++;
      test_done();
    end
  endtask

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd_chk(32'(`CTL_OFFSET), 32'h1, `RESP_OKAY, "control");
    rd_chk(32'h10, 32'h0, `RESP_SLVERR, "unmapped");
    wr_chk(32'(`CAP_ADDR_OFFSET), 32'h0, `RESP_OKAY);
    wr_chk(32'h10, 32'h0, `RESP_SLVERR);
    rd_chk(32'(`CTL_OFFSET), 32'h1, `RESP_OKAY, "control kept");
    rd_chk(32'(`STATUS_OFFSET), 32'h1f3, `RESP_OKAY, "flags");
    lb(30'h00004100, 1'b0, 1, 0);
    check(t0, 5, "single ready");
    check(en1, 3'b101, "enable");
    check(rc2, 3'b111, "read clocks");
    check(i_far.q[1].level, 0, "queue1 pop");
    check(i_far.q[0].level, 600, "queue0 kept");
    rd_chk(32'(`STATUS_OFFSET), 32'h1f1, `RESP_OKAY, "flags");
    lb(30'h00004004, 1'b0, 4, 0);
    check(t0, 5, "burst first");
    for (int i = 1; i < 4; i++) check(rt[i] - rt[i - 1], 2, "burst gap");
    check(i_far.q[0].level, 596, "burst pops");
    lb(30'h00004200, 1'b0, 1, 3);
    check(en1, 3'b111, "turnaround");
    check(t0 > 5, 1, "turnaround wait");
    wr_reg(32'h0);
    lb(30'h08000040, 1'b1, 1, 0);
    check(t0, 1001, "timeout ack");
    #1;
    check(ext_irq_six, 1'b0, "interrupt");
    rd_chk(32'(`CAP_ADDR_OFFSET), 32'h20000100, `RESP_OKAY, "capture address");
    rd_chk(32'(`CAP_ATTR_OFFSET), 32'h80000015, `RESP_OKAY, "capture attr");
    rd_chk(32'(`STATUS_OFFSET), 32'h3f1, `RESP_OKAY, "pending set");
    lb(30'h08000080, 1'b0, 2, 0);
    check(t0, 1001, "burst timeout");
    check(rt[1] - rt[0] inside {[1000:1002]}, 1, "beat timeout");
    rd_chk(32'(`CAP_ATTR_OFFSET), 32'h80000015, `RESP_OKAY, "capture kept");
    wr_reg(32'h1);
    repeat (3) @(posedge aclk);
    check(ext_irq_six, 1'b1, "interrupt clear");
    rd_chk(32'(`STATUS_OFFSET), 32'h1f1, `RESP_OKAY, "pending clear");
    wr_reg(32'h0);
    lb(30'h20000000, 1'b0, 2, 0);
    check(t0, 900, "slow ack");
    check(rt[1] - rt[0], 900, "slow gap");
    repeat (1200) @(posedge aclk);
    check(ext_irq_six, 1'b1, "no timeout");
    wr_reg(32'h1);
    test_done();
  end
endmodule
